// file: inc/cbc_pkg.sv
/*
  Constants, bus-cycle codes and sequencer states for the bus command controller.
  Assumes a single synchronous system clock; one bus state equals two clock cycles.
*/
// Function
// - Status code selects one strobe or none
// - Latch strobe high, none on halt
// - Drive latch strobe holding address each cycle except halt
// - Cascade gate high only on intr ack
// - Transceiver enable high, delayed writes 796
// - Direction high write, low read, rest high
// - Direction changes only with enable low
// - Direction ignores every control input but ready
// - Command strobes all active low
// - Strap high delays command, and enable on writes only
// - Status sampled each cycle starts bus cycle
// - Each bus state lasts two clocks
// - Ready high repeats command state, low ends
// - Strap high, grant high floats commands
package cbc_pkg;

  // ==========================================================
  // Cycle type codes {mem_io, status_bit_one, status_bit_zero}
  localparam logic [2:0] CYC_INTR_ACK_STROBE  = 3'h0;
  localparam logic [2:0] CYC_IORD  = 3'h1;
  localparam logic [2:0] CYC_IOWR  = 3'h2;
  localparam logic [2:0] CYC_HALT  = 3'h4;
  localparam logic [2:0] CYC_MRD   = 3'h5;
  localparam logic [2:0] CYC_MWR   = 3'h6;

  // ==========================================================
  // Strobe vector bit positions
  localparam int STB_MRD  = 0;
  localparam int STB_MWR  = 1;
  localparam int STB_IORD = 2;
  localparam int STB_IOWR = 3;
  localparam int STB_INTR_ACK_STROBE = 4;
  localparam int STB_W    = 5;
  localparam logic [STB_W-1:0] STB_NONE = 5'h00;

  // ==========================================================
  // Phase counter: two clocks per bus state
  localparam logic PH_FIRST  = 1'h0;
  localparam logic PH_SECOND = 1'h1;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_STATUS = 2'b01,
    ST_CMD    = 2'b10
  } cbc_state_t;

  // ==========================================================
  // Decoders: cbc_decode shared by sequencer and outputs, cbc_is_write used by outputs only
  function automatic logic [STB_W-1:0] cbc_decode(input logic [2:0] code);
    logic [STB_W-1:0] s;
    s = STB_NONE;
    unique case (code)
      CYC_INTR_ACK_STROBE: s[STB_INTR_ACK_STROBE] = 1'b1;
      CYC_IORD: s[STB_IORD] = 1'b1;
      CYC_IOWR: s[STB_IOWR] = 1'b1;
      CYC_MRD:  s[STB_MRD]  = 1'b1;
      CYC_MWR:  s[STB_MWR]  = 1'b1;
      default:  s = STB_NONE;
    endcase
    return s;
  endfunction : cbc_decode

  function automatic logic cbc_is_write(input logic [2:0] code);
    return (code == CYC_IOWR) || (code == CYC_MWR);
  endfunction : cbc_is_write

endpackage : cbc_pkg

// file: core/cbc_controller.sv
/*
  Bus command controller: decodes local-bus status into command strobes and
  drives latch strobe, transceiver enable, direction and cascade gate.
  Assumes status, ready and control inputs are synchronous to ref_clk_i.
*/
`timescale 1ns/100ps
module cbc_controller
  import cbc_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  // Status from bus master
  input  wire logic mem_io_i,
  input  wire logic status_bit_one_i,
  input  wire logic status_bit_zero_i,
  // Control inputs
  input  wire logic ready_n_i,
  input  wire logic command_delay_in_i,
  input  wire logic cycle_select_latched_i,
  input  wire logic command_or_grant_gate_i,
  input  wire logic ieee796_timing_strap_i,
  // Command strobes, active low, and command output enable, active high
  output logic      mem_read_strobe_n_o,
  output logic      mem_write_strobe_n_o,
  output logic      io_read_strobe_n_o,
  output logic      io_write_strobe_n_o,
  output logic      intr_ack_strobe_n_o,
  output logic      cmd_oe_o,
  // Control outputs
  output logic      addr_latch_strobe_o,
  output logic      data_transceiver_enable_o,
  output logic      transfer_direction_o,
  output logic      master_cascade_gate_o
);

  // ==========================================================
  // Sequencer state
  cbc_state_t       state_ff, nxt_state;
  logic             phase_ff, nxt_phase;
  logic [2:0]       code_ff, nxt_code;
  logic             sel_ff, nxt_sel;
  logic             cmd_on_ff, nxt_cmd_on;
  logic             wdly_ff, nxt_wdly;

  logic [2:0]       code_in;
  logic             start;
  logic [STB_W-1:0] dec;
  logic             act;

  assign code_in = {mem_io_i, status_bit_one_i, status_bit_zero_i};
  assign start   = ~(status_bit_one_i & status_bit_zero_i);
  assign dec     = cbc_decode(code_ff);
  assign act     = (dec != STB_NONE);

  // ==========================================================
  // Sequencer next state
  always_comb
  begin
    nxt_state  = state_ff;
    nxt_phase  = ~phase_ff;
    nxt_code   = code_ff;
    nxt_sel    = sel_ff;
    nxt_cmd_on = cmd_on_ff;
    nxt_wdly   = wdly_ff;
    unique case (state_ff)
      ST_IDLE:
      begin
        nxt_phase  = PH_FIRST;
        nxt_cmd_on = 1'b0;
        nxt_wdly   = 1'b0;
        if (start)
        begin
          nxt_state = ST_STATUS;
          nxt_phase = PH_SECOND;
          nxt_code  = code_in;
        end
      end
      ST_STATUS:
      begin
        if (phase_ff == PH_SECOND)
        begin
          nxt_state = ST_CMD;
          // Latched once, so an address decoder may settle during status
          nxt_sel   = cycle_select_latched_i;
          // Non-796 mode asserts at command state start unless delayed
          nxt_cmd_on = ~ieee796_timing_strap_i & ~command_delay_in_i;
        end
      end
      ST_CMD:
      begin
        // 796 mode holds off one phase for address and data setup
        if (!cmd_on_ff && !command_delay_in_i)
          nxt_cmd_on = 1'b1;
        if (phase_ff == PH_FIRST)
          nxt_wdly = 1'b1;
        // Ready only counts in the second clock of the state
        if (phase_ff == PH_SECOND && !ready_n_i)
        begin
          nxt_cmd_on = 1'b0;
          nxt_wdly   = 1'b0;
          nxt_state  = start ? ST_STATUS : ST_IDLE;
          nxt_phase  = start ? PH_SECOND : PH_FIRST;
          nxt_code   = start ? code_in : code_ff;
        end
      end
      default:
      begin
        nxt_state = ST_IDLE;
        nxt_phase = PH_FIRST;
      end
    endcase
    // Halt keeps commands off whatever the control inputs
    if (!act)
      nxt_cmd_on = 1'b0;
  end

  // ==========================================================
  // Sequencer registers
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      state_ff  <= ST_IDLE;
      phase_ff  <= PH_FIRST;
      code_ff   <= CYC_HALT;
      sel_ff    <= 1'b0;
      cmd_on_ff <= 1'b0;
      wdly_ff   <= 1'b0;
    end
    else
    begin
      state_ff  <= nxt_state;
      phase_ff  <= nxt_phase;
      code_ff   <= nxt_code;
      sel_ff    <= nxt_sel;
      cmd_on_ff <= nxt_cmd_on;
      wdly_ff   <= nxt_wdly;
    end
  end

  // ==========================================================
  // Output registers
  logic [STB_W-1:0] stb_ff, nxt_stb;
  logic             ale_ff, nxt_ale;
  logic             den_ff, nxt_den;
  logic             dir_ff, nxt_dir;
  logic             mce_ff, nxt_mce;
  logic             oe_ff, nxt_oe;
  logic             gate_ok;
  logic             in_cycle;

  // ==========================================================
  // Output next values
  always_comb
  begin
    // Strap high: gate is active-low grant; low: active-high enable
    gate_ok  = ieee796_timing_strap_i ? ~command_or_grant_gate_i
                                      : command_or_grant_gate_i;
    in_cycle = (nxt_state != ST_IDLE) && cbc_decode(nxt_code) != STB_NONE;
    nxt_oe   = ~(ieee796_timing_strap_i & command_or_grant_gate_i);
    nxt_ale  = (nxt_state == ST_STATUS) && (nxt_phase == PH_SECOND)
               && cbc_decode(nxt_code) != STB_NONE;
    nxt_mce  = in_cycle && (nxt_code == CYC_INTR_ACK_STROBE)
               && (nxt_state == ST_STATUS);
    // Select as latched for this cycle, not the one before
    nxt_stb  = (nxt_cmd_on && nxt_state == ST_CMD && nxt_sel && gate_ok)
               ? cbc_decode(nxt_code) : STB_NONE;
    // Direction: write high, read low, rest high
    nxt_dir  = in_cycle ? cbc_is_write(nxt_code) : 1'b1;
    nxt_den  = 1'b0;
    if (in_cycle && nxt_state == ST_CMD && nxt_sel && gate_ok)
      nxt_den = cbc_is_write(nxt_code)
                ? (~ieee796_timing_strap_i | nxt_wdly)
                : 1'b1;
    // Hold direction until enable has dropped; enable stays off while it moves
    // Keyed on sequencer state, not on the enable, so controls cannot shift it
    if (nxt_dir != dir_ff)
    begin
      if (state_ff == ST_CMD && act)
        nxt_dir = dir_ff;
      nxt_den = 1'b0;
    end
  end

  // ==========================================================
  // Output flops
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      stb_ff <= STB_NONE;
      ale_ff <= 1'b0;
      den_ff <= 1'b0;
      dir_ff <= 1'b1;
      mce_ff <= 1'b0;
      oe_ff  <= 1'b1;
    end
    else
    begin
      stb_ff <= nxt_stb;
      ale_ff <= nxt_ale;
      den_ff <= nxt_den;
      dir_ff <= nxt_dir;
      mce_ff <= nxt_mce;
      oe_ff  <= nxt_oe;
    end
  end

  // ==========================================================
  // Pins; strobes inverted here so the flops reset to zero
  assign mem_read_strobe_n_o       = ~stb_ff[STB_MRD];
  assign mem_write_strobe_n_o      = ~stb_ff[STB_MWR];
  assign io_read_strobe_n_o        = ~stb_ff[STB_IORD];
  assign io_write_strobe_n_o       = ~stb_ff[STB_IOWR];
  assign intr_ack_strobe_n_o       = ~stb_ff[STB_INTR_ACK_STROBE];
  assign cmd_oe_o                  = oe_ff;
  assign addr_latch_strobe_o       = ale_ff;
  assign data_transceiver_enable_o = den_ff;
  assign transfer_direction_o      = dir_ff;
  assign master_cascade_gate_o     = mce_ff;

endmodule : cbc_controller

// file: sim/cbc_controller_chk.sv
/*
  Port-level checker for the bus command controller.
  Assumes it is bound to cbc_controller and sees only its ports.
*/
`timescale 1ns/100ps
module cbc_controller_chk
  import cbc_pkg::*;
(
  // Clock, reset, status and controls
  input wire logic ref_clk_i, rst_i, mem_io_i, status_bit_one_i, status_bit_zero_i,
  input wire logic ready_n_i, command_delay_in_i, cycle_select_latched_i,
  input wire logic command_or_grant_gate_i, ieee796_timing_strap_i,
  // Outputs under watch
  input wire logic mem_read_strobe_n_o, mem_write_strobe_n_o, io_read_strobe_n_o,
  input wire logic io_write_strobe_n_o, intr_ack_strobe_n_o, cmd_oe_o,
  input wire logic addr_latch_strobe_o, data_transceiver_enable_o,
  input wire logic transfer_direction_o, master_cascade_gate_o
);
  logic [2:0] code;
  logic [4:0] act;
  assign code = {mem_io_i, status_bit_one_i, status_bit_zero_i};
  assign act = ~{intr_ack_strobe_n_o, io_write_strobe_n_o, io_read_strobe_n_o,
                 mem_write_strobe_n_o, mem_read_strobe_n_o};
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================
  // Start of status state, fast and 796 timing
  sequence s_fast;
    $rose(addr_latch_strobe_o) && !ieee796_timing_strap_i && !command_delay_in_i
    && cycle_select_latched_i && command_or_grant_gate_i;
  endsequence
  sequence s_slow;
    $rose(addr_latch_strobe_o) && ieee796_timing_strap_i && !command_or_grant_gate_i
    && cycle_select_latched_i;
  endsequence
  a_one_strobe: assert property ($onehot0(act))
    else $error("more than one strobe");
  a_halt_no_ale: assert property ($rose(addr_latch_strobe_o) |->
    $past(code) != CYC_HALT && !(&$past(code[1:0]))) else $error("bad latch strobe");
  a_mce_intack: assert property ($rose(master_cascade_gate_o) |->
    $past(code) == CYC_INTR_ACK_STROBE) else $error("cascade gate off intr ack");
  a_dir_den_off: assert property (!$stable(transfer_direction_o) |->
    !data_transceiver_enable_o && !$past(data_transceiver_enable_o))
    else $error("direction moved with enable");
  a_dir_type: assert property (|act |->
    transfer_direction_o == (act[STB_MWR] || act[STB_IOWR])) else $error("direction");
  a_ready_ends: assert property ($fell(|act) |-> $past(!ready_n_i))
    else $error("strobe ended without ready");
  a_fast_cmd: assert property (s_fast |=> |act && data_transceiver_enable_o)
    else $error("fast command late");
  a_slow_cmd: assert property (s_slow |=> act == 5'h00
    && data_transceiver_enable_o != transfer_direction_o) else $error("796 timing");
  a_grant_float: assert property (ieee796_timing_strap_i && command_or_grant_gate_i
    |=> !cmd_oe_o && !data_transceiver_enable_o) else $error("no float on grant");
endmodule : cbc_controller_chk

bind cbc_controller cbc_controller_chk chk_u (.*);

// file: sim/cbc_master_model.sv
/*
  Local bus master model: puts one status code out for one clock.
  Assumes the bench raises go_i just after a rising edge.
*/
`timescale 1ns/100ps
module cbc_master_model
  import cbc_pkg::*;
(
  // Clock and request
  input  wire logic       ref_clk_i,
  input  wire logic       go_i,
  input  wire logic [2:0] code_i,
  // Status, both status bits idle high
  output logic      [2:0] code_o
);
  initial code_o = 3'h7;
  // ==========================================================
  // Status only held for the first clock, as a real master may
  always @(posedge ref_clk_i)
  begin
    code_o <= #1 go_i ? code_i : {code_i[2], 2'b11};
  end
endmodule : cbc_master_model

// file: sim/cpu_bus_command_controller_bench.sv
/*
  Self-checking bench for the bus command controller.
  Assumes the checker is bound in and the master model drives status.
*/
`timescale 1ns/100ps
module cpu_bus_command_controller_bench
  import cbc_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, go = 1'b0, rdy_n = 1'b0, dly = 1'b0;
  logic sel = 1'b1, gate = 1'b1, strap = 1'b0;
  logic rd_n, wr_n, ird_n, iwr_n, ia_n, oe, ale, data_transceiver_enable, dir, master_cascade_gate;
  logic r_ale, r_mce, r_den, r_oe, r_dir;
  logic [2:0] code = 3'h7, st;
  logic [4:0] stb, r_stb, e;
  int r_k, r_n, err_total = 0, n_tests = 0;
  localparam logic [4:0] EXP [8] = '{5'h10, 5'h04, 5'h08, 5'h00,
                                     5'h00, 5'h01, 5'h02, 5'h00};
  assign stb = ~{ia_n, iwr_n, ird_n, wr_n, rd_n};
  always #2.5 clk = ~clk;
  cbc_master_model mst_u (.ref_clk_i(clk), .go_i(go), .code_i(code), .code_o(st));
  cbc_controller dut_u (.ref_clk_i(clk), .rst_i(rst), .mem_io_i(st[2]),
    .status_bit_one_i(st[1]), .status_bit_zero_i(st[0]), .ready_n_i(rdy_n),
    .command_delay_in_i(dly), .cycle_select_latched_i(sel),
    .command_or_grant_gate_i(gate), .ieee796_timing_strap_i(strap),
    .mem_read_strobe_n_o(rd_n), .mem_write_strobe_n_o(wr_n), .io_read_strobe_n_o(ird_n),
    .io_write_strobe_n_o(iwr_n), .intr_ack_strobe_n_o(ia_n), .cmd_oe_o(oe),
    .addr_latch_strobe_o(ale), .data_transceiver_enable_o(data_transceiver_enable),
    .transfer_direction_o(dir), .master_cascade_gate_o(master_cascade_gate));
  // ==========================================================
  // One bus cycle: w wait states, d clocks of command delay
  task automatic run(input logic [2:0] c, input int w, input int d);
    int k;
    {r_stb, r_ale, r_mce, r_den, r_oe, r_dir, r_k, r_n} = {5'h00, 5'b00011, 64'h0};
    @(posedge clk);
    #1 code = c;
    go = 1'b1;
    @(posedge clk);
    #1 go = 1'b0;
    @(posedge clk);
    #1 rdy_n = (w > 0);
    dly = (d > 0);
    // First pass samples the clock that carries the latch strobe
    for (k = 1; k <= 5 + 2 * w; k++)
    begin
      if (k == 2 + 2 * w) rdy_n = 1'b0;
      if (d > 0 && k == 1 + d) dly = 1'b0;
      if (stb != 5'h00 && r_k == 0) {r_k, r_dir} = {k, dir};
      r_n += int'(stb != 5'h00);
      // Cascade latch keeps what stood while the latch strobe was high
      {r_stb, r_ale, r_mce, r_den, r_oe} = {r_stb | stb, r_ale | ale, r_mce | (master_cascade_gate & ale),
                                            r_den | data_transceiver_enable, r_oe & oe};
      @(posedge clk);
      #1;
    end
  endtask : run
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // ==========================================================
  // Scenarios
  task automatic sc_decode;
    for (int i = 0; i < 8; i++)
    begin
      e = EXP[i];
      run(i[2:0], 0, 0);
      chk(16'(r_stb), 16'(e));
      chk(16'({r_ale, r_den, r_mce}), 16'({e != 0, e != 0, i == 0}));
      chk(16'(r_dir), 16'((e & 5'h15) == 5'h00));
      chk(16'(r_k), (e != 0) ? 16'h0002 : 16'h0000);
      chk(16'({dir, data_transceiver_enable}), 16'h0002);
    end
  endtask : sc_decode
  task automatic sc_wait;
    run(CYC_MWR, 2, 0);
    chk(16'(r_n), 16'h0006);
  endtask : sc_wait
  task automatic sc_796;
    {strap, gate} = 2'b10;
    run(CYC_IORD, 1, 0);
    chk({8'(r_k), 8'(r_n)}, 16'h0303);
    run(CYC_IOWR, 1, 0);
    chk(16'({r_stb, 8'(r_k)}), 16'({5'h08, 8'h03}));
    {strap, gate} = 2'b01;
  endtask : sc_796
  task automatic sc_delay;
    run(CYC_MRD, 1, 1);
    chk({8'(r_k), 8'(r_n)}, 16'h0303);
  endtask : sc_delay
  task automatic sc_select;
    sel = 1'b0;
    run(CYC_MRD, 0, 0);
    chk(16'({r_stb, r_ale, r_den}), 16'h0002);
    sel = 1'b1;
    // Enable low in fast mode suppresses commands but still drives them
    gate = 1'b0;
    run(CYC_IOWR, 0, 0);
    chk(16'({r_stb, r_ale, r_den, r_oe}), 16'h0005);
    gate = 1'b1;
  endtask : sc_select
  task automatic sc_grant;
    {strap, gate} = 2'b11;
    run(CYC_MRD, 1, 0);
    chk(16'({r_oe, r_den, r_ale}), 16'h0001);
    {strap, gate} = 2'b01;
  endtask : sc_grant
  task automatic print_verdict;
    if (err_total == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  initial
  begin
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    sc_decode();
    sc_wait();
    sc_796();
    sc_delay();
    sc_select();
    sc_grant();
    print_verdict();
  end
endmodule : cpu_bus_command_controller_bench
